//--- logic/vgsp_pkg.sv
package vgsp_pkg;
   localparam int CMD_BITS       = 8;
   localparam int DATA_BITS      = 16;
   localparam int FRAME_BITS     = CMD_BITS + DATA_BITS;
   localparam int CNT_W          = 5;
   localparam int SYNC_STAGES    = 2;
   localparam int RW_BIT_POS     = 7;
   localparam int ADDR_BITS      = 7;
   localparam logic RW_READ_VAL  = 1'b1;
   localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
   localparam logic [CNT_W-1:0] CNT_ONE  = 5'h01;
   localparam logic [15:0] DATA_RESET    = 16'h0000;

   typedef enum logic [1:0] {
      VGSP_IDLE = 2'b00,
      VGSP_CMD  = 2'b01,
      VGSP_DATA = 2'b10,
      VGSP_DONE = 2'b11
   } vgsp_state_t;
endpackage : vgsp_pkg

//--- logic/vgsp_port.sv
`timescale 1ns/100ps
module vgsp_port
   import vgsp_pkg::*;
#(
   parameter bit MSB_FIRST   = 1'b1,
   parameter bit SAMPLE_RISE = 1'b1
) (
   input  wire logic                 core_clk_in,
   input  wire logic                 rst_in,
   input  wire logic                 sel_n_in,
   input  wire logic                 sclk_in,
   input  wire logic                 sdio_in,
   output logic                      sdio_out,
   output logic                      sdio_oe_out,
   input  wire logic [DATA_BITS-1:0] rd_data_in,
   output logic [ADDR_BITS-1:0]      rd_addr_out,
   output logic [ADDR_BITS-1:0]      wr_addr_out,
   output logic [DATA_BITS-1:0]      wr_data_out,
   output logic                      wr_stb_out,
   output logic                      busy_out
);
   logic [2:0]               sync_w;
   logic                     sel_n_s;
   logic                     sclk_s;
   logic                     sdio_s;
   logic                     sclk_d_r;
   logic                     sclk_d_nxt;
   vgsp_state_t              state_r;
   vgsp_state_t              state_nxt;
   logic [CNT_W-1:0]         cnt_r;
   logic [CNT_W-1:0]         cnt_nxt;
   logic [CMD_BITS-1:0]      cmd_r;
   logic [CMD_BITS-1:0]      cmd_nxt;
   logic [DATA_BITS-1:0]     din_r;
   logic [DATA_BITS-1:0]     din_nxt;
   logic [DATA_BITS-1:0]     dout_r;
   logic [DATA_BITS-1:0]     dout_nxt;
   logic                     sdo_r;
   logic                     sdo_nxt;
   logic                     oe_r;
   logic                     oe_nxt;
   logic [ADDR_BITS-1:0]     rda_r;
   logic [ADDR_BITS-1:0]     rda_nxt;
   logic [ADDR_BITS-1:0]     wra_r;
   logic [ADDR_BITS-1:0]     wra_nxt;
   logic [DATA_BITS-1:0]     wrd_r;
   logic [DATA_BITS-1:0]     wrd_nxt;
   logic                     wst_r;
   logic                     wst_nxt;
   logic                     busy_r;
   logic                     busy_nxt;
   logic                     samp_edge;
   logic                     launch_edge;
   logic                     is_read;
   logic [CMD_BITS-1:0]      cmd_full;

   // elaboration checks on the fixed command layout and the bit counter width
   if (ADDR_BITS + 1 != CMD_BITS) begin : g_cmd_chk
      $error("command layout does not fit");
   end
   if (FRAME_BITS >= (1 << CNT_W)) begin : g_cnt_chk
      $error("bit counter too narrow");
   end

   // pins sampled twice before use
   vgsp_sync #(.WIDTH(3)) vgsp_sync_i (
      .core_clk_in  (core_clk_in),
      .rst_in       (rst_in),
      .async_in     ({sel_n_in, sclk_in, sdio_in}),
      .reset_val_in (3'h4),
      .sync_out     (sync_w)
   );
   assign sel_n_s = sync_w[2];
   assign sclk_s  = sync_w[1];
   assign sdio_s  = sync_w[0];

   function automatic logic [DATA_BITS-1:0] shift_in(input logic [DATA_BITS-1:0] v, input logic b);
      shift_in = MSB_FIRST ? {v[DATA_BITS-2:0], b} : {b, v[DATA_BITS-1:1]};
   endfunction : shift_in

   function automatic logic head_bit(input logic [DATA_BITS-1:0] v);
      head_bit = MSB_FIRST ? v[DATA_BITS-1] : v[0];
   endfunction : head_bit

   assign samp_edge   = SAMPLE_RISE ? (sclk_s & ~sclk_d_r) : (~sclk_s & sclk_d_r);
   assign launch_edge = SAMPLE_RISE ? (~sclk_s & sclk_d_r) : (sclk_s & ~sclk_d_r);
   assign cmd_full    = MSB_FIRST ? {cmd_r[CMD_BITS-2:0], sdio_s} : {sdio_s, cmd_r[CMD_BITS-1:1]};
   assign is_read     = (cmd_r[RW_BIT_POS] == RW_READ_VAL);

   always_comb begin
      sclk_d_nxt = sclk_s;
      state_nxt  = state_r;
      cnt_nxt    = cnt_r;
      cmd_nxt    = cmd_r;
      din_nxt    = din_r;
      dout_nxt   = dout_r;
      sdo_nxt    = sdo_r;
      oe_nxt     = oe_r;
      rda_nxt    = rda_r;
      wra_nxt    = wra_r;
      wrd_nxt    = wrd_r;
      wst_nxt    = 1'b0;
      busy_nxt   = (state_r != VGSP_IDLE);
      if (sel_n_s) begin
         state_nxt = VGSP_IDLE;
         cnt_nxt   = CNT_ZERO;
         oe_nxt    = 1'b0;
      end else begin
         case (state_r)
            VGSP_IDLE: begin
               state_nxt = VGSP_CMD;
               cnt_nxt   = CNT_ZERO;
            end
            VGSP_CMD: begin
               if (samp_edge) begin
                  cmd_nxt = cmd_full;
                  cnt_nxt = cnt_r + CNT_ONE;
                  if (cnt_r == 5'(CMD_BITS - 1)) begin
                     state_nxt = VGSP_DATA;
                     rda_nxt   = cmd_full[ADDR_BITS-1:0];
                  end
               end
            end
            VGSP_DATA: begin
               // read data launched on the opposite edge
               if (launch_edge && is_read) begin
                  sdo_nxt  = head_bit(dout_r);
                  dout_nxt = shift_in(dout_r, 1'b0);
                  oe_nxt   = 1'b1;
               end
               if (samp_edge) begin
                  din_nxt = shift_in(din_r, sdio_s);
                  cnt_nxt = cnt_r + CNT_ONE;
                  if (cnt_r == 5'(FRAME_BITS - 1)) begin
                     state_nxt = VGSP_DONE;
                     if (!is_read) begin
                        wra_nxt = cmd_r[ADDR_BITS-1:0];
                        wrd_nxt = shift_in(din_r, sdio_s);
                        wst_nxt = 1'b1;
                     end
                  end
               end
            end
            VGSP_DONE: begin
               if (launch_edge) oe_nxt = 1'b0;
            end
            default: state_nxt = VGSP_IDLE;
         endcase
      end
      // load read word once the address has been presented
      if (state_r == VGSP_CMD && state_nxt == VGSP_DATA) dout_nxt = DATA_RESET;
      if (state_r == VGSP_DATA && cnt_r == 5'(CMD_BITS) && !samp_edge && !launch_edge && !oe_r)
         dout_nxt = rd_data_in;
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         sclk_d_r <= 1'b0;
         state_r  <= VGSP_IDLE;
         cnt_r    <= CNT_ZERO;
         cmd_r    <= '0;
         din_r    <= DATA_RESET;
         dout_r   <= DATA_RESET;
         sdo_r    <= 1'b0;
         oe_r     <= 1'b0;
         rda_r    <= '0;
         wra_r    <= '0;
         wrd_r    <= DATA_RESET;
         wst_r    <= 1'b0;
         busy_r   <= 1'b0;
      end else begin
         sclk_d_r <= sclk_d_nxt;
         state_r  <= state_nxt;
         cnt_r    <= cnt_nxt;
         cmd_r    <= cmd_nxt;
         din_r    <= din_nxt;
         dout_r   <= dout_nxt;
         sdo_r    <= sdo_nxt;
         oe_r     <= oe_nxt;
         rda_r    <= rda_nxt;
         wra_r    <= wra_nxt;
         wrd_r    <= wrd_nxt;
         wst_r    <= wst_nxt;
         busy_r   <= busy_nxt;
      end
   end

   assign sdio_out    = sdo_r;
   assign sdio_oe_out = oe_r;
   assign rd_addr_out = rda_r;
   assign wr_addr_out = wra_r;
   assign wr_data_out = wrd_r;
   assign wr_stb_out  = wst_r;
   assign busy_out    = busy_r;

   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);

   oe_off_desel_a: assert property (sel_n_s |=> !oe_r) else $error("driver on while deselected");
   frame_len_a: assert property (wst_r |-> $past(cnt_r) == 5'(FRAME_BITS - 1)) else $error("write before 24 bits");
   no_write_read_a: assert property (wst_r |-> !$past(is_read)) else $error("strobe on read");
   oe_read_only_a: assert property ($rose(oe_r) |-> is_read && state_r == VGSP_DATA) else $error("drive outside read");
   done_hold_a: assert property (state_r == VGSP_DONE && !sel_n_s |=> state_r == VGSP_DONE) else $error("left done");
   desel_idle_a: assert property (sel_n_s |=> state_r == VGSP_IDLE && cnt_r == CNT_ZERO) else $error("not idle");
   cnt_bound_a: assert property (cnt_r <= 5'(FRAME_BITS)) else $error("counter overrun");
   strobe_pulse_a: assert property (wst_r |=> !wst_r) else $error("strobe too long");
   oe_done_off_a: assert property (state_r == VGSP_DONE && launch_edge |=> !oe_r)
      else $error("driver kept after frame");
   rda_hold_a: assert property (state_r == VGSP_DATA && !sel_n_s |=> $stable(rda_r))
      else $error("read address moved");

   write_cov_c: cover property (wst_r);
   read_cov_c: cover property (oe_r ##1 state_r == VGSP_DONE);
   abort_cov_c: cover property (state_r == VGSP_DATA ##1 sel_n_s);
   surplus_cov_c: cover property (state_r == VGSP_DONE && samp_edge);
endmodule : vgsp_port

//--- logic/vgsp_sync.sv
`timescale 1ns/100ps
module vgsp_sync
   import vgsp_pkg::*;
#(
   parameter int WIDTH = 3
) (
   input  wire logic             core_clk_in,
   input  wire logic             rst_in,
   input  wire logic [WIDTH-1:0] async_in,
   input  wire logic [WIDTH-1:0] reset_val_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;
   logic [WIDTH-1:0] meta_nxt;
   logic [WIDTH-1:0] sync_nxt;

   if (SYNC_STAGES != 2) begin : g_stage_chk
      $error("vgsp_sync supports two stages only");
   end

   always_comb begin
      meta_nxt = async_in;
      sync_nxt = meta_r;
   end

   // reset value is a constant tie-off at the instance
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         meta_r <= reset_val_in;
         sync_r <= reset_val_in;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign sync_out = sync_r;
endmodule : vgsp_sync

//--- verif/vgsp_host.sv
`timescale 1ns/100ps
module vgsp_host (
   output logic        sel_n_out,
   output logic        sclk_out,
   output logic        sdio_out,
   input  wire logic   sdio_in,
   output logic [15:0] rd_word_out,
   output logic        rd_vld_out
);
   initial begin
      sel_n_out = 1'b1;
      sclk_out = 1'b0;
      sdio_out = 1'b0;
      rd_word_out = 16'h0000;
      rd_vld_out = 1'b0;
   end
   task automatic frame(input logic [31:0] bits, input int nbits);
      sel_n_out = 1'b0;
      #16;
      for (int i = 0; i < nbits; i++) begin
         // released line toggles so a stray sample is caught
         sdio_out = (bits[31] && i >= 8) ? ~sdio_out : bits[31-i];
         #16 sclk_out = 1'b1;
         #16;
         if (i >= 8 && i < 24) rd_word_out[23-i] = sdio_in;
         sclk_out = 1'b0;
      end
      #16 sel_n_out = 1'b1;
      sdio_out = ~sdio_out;
      rd_vld_out = bits[31];
      #4 rd_vld_out = 1'b0;
   endtask : frame
   // clock and data wiggled while deselected on purpose
   task automatic idle_clk(input int n);
      for (int i = 0; i < n; i++) begin
         sdio_out = 1'($urandom);
         #16 sclk_out = 1'b1;
         #16 sclk_out = 1'b0;
      end
   endtask : idle_clk
endmodule : vgsp_host

//--- verif/vgsp_port_tb.sv
`timescale 1ns/100ps
module vgsp_port_tb;
   import vgsp_pkg::*;
   logic                 core_clk_in = 1'b0;
   logic                 rst_in = 1'b1;
   logic                 sel_n, sclk, h_sdio, d_sdio, d_oe, sdio_w, rd_vld, wr_stb, busy;
   logic [DATA_BITS-1:0] rd_data = 16'h0000;
   logic [DATA_BITS-1:0] wr_data, rd_word;
   logic [ADDR_BITS-1:0] rd_addr, wr_addr;
   logic [22:0]          exp_q[$];
   logic [22:0]          ex;
   int                   err_total = 0;
   int                   total_checks = 0;
   int                   cyc = 0;
   assign sdio_w = d_oe ? d_sdio : h_sdio;
   vgsp_port vgsp_port_i (.core_clk_in(core_clk_in), .rst_in(rst_in), .sel_n_in(sel_n), .sclk_in(sclk),
      .sdio_in(sdio_w), .sdio_out(d_sdio), .sdio_oe_out(d_oe), .rd_data_in(rd_data), .rd_addr_out(rd_addr),
      .wr_addr_out(wr_addr), .wr_data_out(wr_data), .wr_stb_out(wr_stb), .busy_out(busy));
   vgsp_host vgsp_host_i (.sel_n_out(sel_n), .sclk_out(sclk), .sdio_out(h_sdio), .sdio_in(sdio_w),
      .rd_word_out(rd_word), .rd_vld_out(rd_vld));
   initial forever #2 core_clk_in = ~core_clk_in;
   task automatic check(input string name, input logic [22:0] seen, input logic [22:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test
   task automatic access(input logic rd, input int nbits);
      logic [6:0] a;
      logic [15:0] d;
      logic [7:0] x;
      a = 7'($urandom);
      d = 16'($urandom);
      x = 8'($urandom);
      rd_data = rd ? d : ~d;
      exp_q.push_back({a, d});
      vgsp_host_i.frame({rd, a, d, x}, nbits);
      repeat (6) @(negedge core_clk_in);
      check("oe after frame", {22'h0, d_oe}, 23'h0);
      check("busy after frame", {22'h0, busy}, 23'h0);
   endtask : access
   always @(posedge core_clk_in) begin
      cyc <= cyc + 1;
      if (wr_stb === 1'b1 || rd_vld === 1'b1) begin
         ex = exp_q.size() > 0 ? exp_q.pop_front() : ~(wr_stb === 1'b1 ? {wr_addr, wr_data} : {rd_addr, rd_word});
         if (wr_stb === 1'b1)
            check("write word", {wr_addr, wr_data}, ex);
         else
            check("read word", {rd_addr, rd_word}, ex);
      end
      if (cyc == 20000) begin
         err_total++;
         finish_test();
      end
   end
   initial begin
      rd_data = 16'($urandom(56669));
      repeat (3) @(negedge core_clk_in);
      rst_in = 1'b0;
      repeat (3) @(negedge core_clk_in);
      access(1'b0, 24);
      access(1'b1, 24);
      $display("test basic done");
      // surplus bits must not disturb the word
      access(1'b0, 32);
      access(1'b1, 32);
      $display("test surplus done");
      vgsp_host_i.idle_clk(8);
      check("oe deselected", {22'h0, d_oe}, 23'h0);
      $display("test deselected done");
      for (int i = 0; i < 8; i++) access(1'($urandom), 24);
      $display("test random done");
      repeat (10) @(negedge core_clk_in);
      check("queue empty", 23'(exp_q.size()), 23'h0);
      finish_test();
   end
endmodule : vgsp_port_tb
